// ==== hdl/adc_command_and_cycle_trigger.v ====
// Overview of operation
// [R1] A pointer write with a nonzero channel command starts a conversion.
// [R2] The master writes zero into the two unused upper command bits.
// [R3] Only the first command bit selects input one; only the second selects input two.
// [R4] Both command bits set converts input one, then input two.
// [R5] All command bits zero leaves command mode off; no conversion starts.
// [R6] Power-up starts on the fifth falling clock edge of the pointer byte.
// [R7] Conversion follows the command bits; wake plus conversion is about 3 us.
// [R8] The master points at the result register before reading a result.
// [R9] The master re-addresses for a read, which returns the commanded result.
// [R10] With both inputs, a four-byte read returns input one then input two.
// [R11] Further acknowledged read bytes keep the selected inputs converting.
// [R12] A read of an unfinished result holds the clock low until done.
// [R13] A stop condition or a not-acknowledge ends command-mode converting.
// [R14] The cycle timer register is eight bits; only three low bits count.
// [R15] A nonzero cycle code enables periodic conversions at one of seven intervals.
// [R16] In cycle mode the core powers down between conversions.
// [R17] Writing a zero cycle code stops periodic conversions.
// [R18] Cycle-mode inputs come from the two channel bits of the configuration.
// [R19] Cycle mode walks enabled inputs from the lowest and loops around.
// [R20] A pointer-only write selects the register that later reads return.
// [R21] Cycle codes map to intervals through a parameterised lookup table.
`timescale 1ns/10ps
`include "adc_trigger_regs.vh"
module adc_command_and_cycle_trigger #(
  parameter [6:0]  DEV_ADDR      = 7'h28,
  parameter [31:0] INTERVAL_US_1 = 32'd1000,
  parameter [31:0] INTERVAL_US_2 = 32'd2000,
  parameter [31:0] INTERVAL_US_3 = 32'd4000,
  parameter [31:0] INTERVAL_US_4 = 32'd8000,
  parameter [31:0] INTERVAL_US_5 = 32'd16000,
  parameter [31:0] INTERVAL_US_6 = 32'd32000,
  parameter [31:0] INTERVAL_US_7 = 32'd64000
) (
  input  wire        CORE_CLK_I,
  input  wire        RESET_I,
  input  wire        SCL_I,
  output wire        SCL_O,
  output wire        SCL_OE_O,
  input  wire        SDA_I,
  output wire        SDA_O,
  output wire        SDA_OE_O,
  input  wire [11:0] SAR_RESULT_I,
  output wire        ANALOG_POWER_UP_O,
  output wire        SAMPLE_HOLD_O,
  output wire [1:0]  CHANNEL_SEL_O,
  output wire        CONV_BUSY_O
);

  localparam integer WAKE_INT = (`WAKE_NS * `CLK_MHZ + 999) / 1000;
  localparam integer CONV_INT = (`CONV_NS * `CLK_MHZ + 999) / 1000;
  localparam [15:0]  WAKE_CYC = WAKE_INT[15:0];
  localparam [15:0]  CONV_CYC = CONV_INT[15:0];

  localparam [6:0] S_IDLE  = 7'b0000001;
  localparam [6:0] S_ADDR  = 7'b0000010;
  localparam [6:0] S_ACK_A = 7'b0000100;
  localparam [6:0] S_WR    = 7'b0001000;
  localparam [6:0] S_ACK_W = 7'b0010000;
  localparam [6:0] S_RD    = 7'b0100000;
  localparam [6:0] S_ACK_R = 7'b1000000;

  reg  [6:0]  st_q;
  reg  [3:0]  bit_q;
  reg  [7:0]  sh_q;
  reg         rw_q;
  reg         wbyte_q;
  reg         rbyte_q;
  reg         sda_oe_q;
  reg         stretch_q;
  reg         scl_q;
  reg         sda_q;
  reg  [3:0]  ptr_q;
  reg  [1:0]  cmd_q;
  reg         cmd_act_q;
  reg  [7:0]  cfg_q;
  reg  [7:0]  cyc_q;
  reg  [15:0] out_q;
  reg  [15:0] pend_q;
  reg         pend_v_q;
  reg         fresh_q;
  reg  [31:0] tick_q;
  reg         last_ch_q;

  reg         start;
  reg         start_ch;
  reg         abort;
  reg         consume;
  reg         cont_read;

  wire        rise      = ~scl_q & SCL_I;
  wire        fall      = scl_q & ~SCL_I;
  wire        start_cnd = scl_q & SCL_I & sda_q & ~SDA_I;
  wire        stop_cnd  = scl_q & SCL_I & ~sda_q & SDA_I;
  wire        busy;
  wire        done;
  wire        done_ch;
  wire [2:0]  cyc_code  = cyc_q[`CYC_CODE_MSB:0];
  wire [1:0]  cfg_ch    = {cfg_q[`CFG_CH_UPPER_BIT], cfg_q[`CFG_CH_LOWER_BIT]};
  wire [15:0] res_word  = {3'b000, done_ch, SAR_RESULT_I};
  wire        addr_hit  = (sh_q[7:1] == DEV_ADDR);
  wire        rd_result = (ptr_q == `PTR_RESULT);

  function [31:0] interval_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h1:    interval_cycles = INTERVAL_US_1 * `CLK_MHZ;
        3'h2:    interval_cycles = INTERVAL_US_2 * `CLK_MHZ;
        3'h3:    interval_cycles = INTERVAL_US_3 * `CLK_MHZ;
        3'h4:    interval_cycles = INTERVAL_US_4 * `CLK_MHZ;
        3'h5:    interval_cycles = INTERVAL_US_5 * `CLK_MHZ;
        3'h6:    interval_cycles = INTERVAL_US_6 * `CLK_MHZ;
        3'h7:    interval_cycles = INTERVAL_US_7 * `CLK_MHZ;
        default: interval_cycles = 32'h00000000;
      endcase
    end
  endfunction

  // Selects the byte presented for the current register pointer.
  function [7:0] read_byte;
    input [3:0] ptr;
    input       low;
    input [15:0] res;
    input [7:0] cfg;
    input [7:0] cyc;
    begin
      case (ptr)
        `PTR_RESULT: read_byte = low ? res[7:0] : res[15:8];
        `PTR_CONFIG: read_byte = cfg;
        `PTR_CYCLE:  read_byte = cyc;
        default:     read_byte = 8'h00;
      endcase
    end
  endfunction

  wire [7:0] first_byte = read_byte(ptr_q, 1'b0, out_q, cfg_q, cyc_q);
  wire [7:0] next_byte  = read_byte(ptr_q, ~rbyte_q, out_q, cfg_q, cyc_q);

  assign SDA_O             = 1'b0;
  assign SDA_OE_O          = sda_oe_q;
  assign SCL_O             = 1'b0;
  assign SCL_OE_O          = stretch_q;
  assign CONV_BUSY_O       = busy;
  assign CHANNEL_SEL_O     = done_ch ? 2'b10 : 2'b01;

  adc_conv_sequencer #(
    .WAKE_CYC (WAKE_CYC),
    .CONV_CYC (CONV_CYC)
  ) u_conv (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RESET_I),
    .start_i (start),
    .chan_i  (start_ch),
    .abort_i (abort),
    .busy_o  (busy),
    .power_o (ANALOG_POWER_UP_O),
    .hold_o  (SAMPLE_HOLD_O),
    .done_o  (done),
    .chan_o  (done_ch)
  );

  // Conversion requests from command mode and from the cycle timer.
  always @* begin
    start    = 1'b0;
    start_ch = 1'b0;
    abort    = 1'b0;
    consume  = 1'b0;
    cont_read = 1'b0;
    if (st_q == S_ACK_R && rise && rd_result && rbyte_q) begin
      consume   = 1'b1;
      cont_read = ~SDA_I;
    end
    if (cmd_act_q && (stop_cnd || (st_q == S_ACK_R && rise && SDA_I))) begin
      abort = 1'b1; // R13
    end else if (st_q == S_WR && fall && ~wbyte_q && bit_q == `CMD_DECIDE_FALL &&
                 (sh_q[2] | sh_q[1])) begin
      start    = 1'b1; // R1 R6 R7
      start_ch = ~sh_q[1]; // R3
    end else if (cmd_act_q && done && ~done_ch && cmd_q == 2'b11) begin
      start    = 1'b1; // R4 R10
      start_ch = 1'b1;
    end else if (cmd_act_q && cont_read && ~busy) begin
      // The consumed pair frees the queue in this cycle, so a restart cannot overrun it.
      start    = 1'b1; // R11
      start_ch = ~cmd_q[0];
    end else if (~cmd_act_q && cyc_code != 3'h0 && tick_q == 32'h00000001 &&
                 cfg_ch != 2'b00 && ~busy) begin
      start    = 1'b1; // R15 R18
      start_ch = (cfg_ch == 2'b11) ? ~last_ch_q : cfg_ch[1]; // R19
    end
  end

  // Interval timer for automatic cycle mode.
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tick_q    <= 32'h00000000;
      last_ch_q <= 1'b1;
    end else begin
      if (cyc_code == 3'h0) begin
        tick_q    <= 32'h00000000; // R17
        last_ch_q <= 1'b1;
      end else if (tick_q <= 32'h00000001) begin
        tick_q <= interval_cycles(cyc_code); // R21
      end else begin
        tick_q <= tick_q - 32'h00000001;
      end
      if (start && ~cmd_act_q) begin
        last_ch_q <= start_ch;
      end
    end
  end

  // Result holding: the latest unread result and one queued behind it.
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      out_q    <= 16'h0000;
      pend_q   <= 16'h0000;
      pend_v_q <= 1'b0;
      fresh_q  <= 1'b0;
    end else if (consume) begin
      if (pend_v_q) begin
        out_q    <= pend_q; // R10
        fresh_q  <= 1'b1;
        pend_v_q <= done;
        pend_q   <= res_word;
      end else if (done) begin
        out_q   <= res_word;
        fresh_q <= 1'b1;
      end else begin
        fresh_q <= 1'b0;
      end
    end else if (done) begin
      if (fresh_q && cmd_act_q) begin
        pend_q   <= res_word;
        pend_v_q <= 1'b1;
      end else begin
        out_q   <= res_word;
        fresh_q <= 1'b1;
      end
    end
  end

  // Serial slave port.
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_q      <= S_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      rw_q      <= 1'b0;
      wbyte_q   <= 1'b0;
      rbyte_q   <= 1'b0;
      sda_oe_q  <= 1'b0;
      stretch_q <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      ptr_q     <= `PTR_RESULT;
      cmd_q     <= 2'b00;
      cmd_act_q <= 1'b0;
      cfg_q     <= `CFG_RESET;
      cyc_q     <= `CYC_RESET;
    end else begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
      if (abort) begin
        cmd_act_q <= 1'b0; // R13
      end
      if (stretch_q && (fresh_q || ~busy)) begin
        stretch_q <= 1'b0; // R12
      end
      if (stop_cnd) begin
        st_q      <= S_IDLE;
        sda_oe_q  <= 1'b0;
        stretch_q <= 1'b0;
      end else if (start_cnd) begin
        st_q     <= S_ADDR;
        bit_q    <= 4'h0;
        sda_oe_q <= 1'b0;
      end else begin
        case (st_q)
          S_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          S_ADDR: begin
            if (rise) begin
              sh_q  <= {sh_q[6:0], SDA_I};
              bit_q <= bit_q + 4'h1;
            end else if (fall && bit_q == `BYTE_BITS) begin
              if (addr_hit) begin
                sda_oe_q <= 1'b1;
                rw_q     <= sh_q[0];
                st_q     <= S_ACK_A;
                if (sh_q[0] && rd_result && busy && ~fresh_q) begin
                  stretch_q <= 1'b1; // R12
                end
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_ACK_A: begin
            if (fall) begin
              bit_q <= 4'h0;
              if (rw_q) begin
                st_q     <= S_RD;
                rbyte_q  <= 1'b0;
                sh_q     <= first_byte; // R8 R9
                sda_oe_q <= ~first_byte[7];
              end else begin
                st_q     <= S_WR;
                wbyte_q  <= 1'b0;
                sda_oe_q <= 1'b0;
              end
            end
          end
          S_WR: begin
            if (rise) begin
              sh_q  <= {sh_q[6:0], SDA_I};
              bit_q <= bit_q + 4'h1;
            end else if (fall && ~wbyte_q && bit_q == `CMD_DECIDE_FALL) begin
              // The upper two command bits are ignored by the decode.
              cmd_q     <= {sh_q[2], sh_q[1]}; // R2 R3
              cmd_act_q <= sh_q[2] | sh_q[1]; // R5
            end else if (fall && bit_q == `BYTE_BITS) begin
              sda_oe_q <= 1'b1;
              st_q     <= S_ACK_W;
              if (~wbyte_q) begin
                ptr_q <= sh_q[`PTR_FIELD_MSB:0]; // R20
              end else if (ptr_q == `PTR_CONFIG) begin
                cfg_q <= sh_q; // R18
              end else if (ptr_q == `PTR_CYCLE) begin
                cyc_q <= sh_q; // R14
              end
            end
          end
          S_ACK_W: begin
            if (fall) begin
              sda_oe_q <= 1'b0;
              bit_q    <= 4'h0;
              wbyte_q  <= 1'b1;
              st_q     <= S_WR;
            end
          end
          S_RD: begin
            if (rise) begin
              bit_q <= bit_q + 4'h1;
            end else if (fall) begin
              if (bit_q == `BYTE_BITS) begin
                sda_oe_q <= 1'b0;
                st_q     <= S_ACK_R;
              end else begin
                sda_oe_q <= ~sh_q[6];
                sh_q     <= {sh_q[6:0], 1'b0};
              end
            end
          end
          S_ACK_R: begin
            if (rise && SDA_I) begin
              st_q <= S_IDLE;
            end else if (fall) begin
              rbyte_q  <= ~rbyte_q;
              bit_q    <= 4'h0;
              sh_q     <= next_byte;
              sda_oe_q <= ~next_byte[7];
              st_q     <= S_RD;
            end
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // adc_command_and_cycle_trigger

// ==== hdl/adc_conv_sequencer.v ====
// Power-up and conversion timing of the successive-approximation core.
`timescale 1ns/10ps
module adc_conv_sequencer #(
  parameter [15:0] WAKE_CYC = 16'd250,
  parameter [15:0] CONV_CYC = 16'd500
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire        chan_i,
  input  wire        abort_i,
  output wire        busy_o,
  output reg         power_o,
  output reg         hold_o,
  output reg         done_o,
  output reg         chan_o
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_WAKE = 3'b010;
  localparam [2:0] S_CONV = 3'b100;

  reg [2:0]  st_q;
  reg [15:0] cnt_q;

  assign busy_o = ~st_q[0];

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q    <= S_IDLE;
      cnt_q   <= 16'h0000;
      power_o <= 1'b0;
      hold_o  <= 1'b0;
      done_o  <= 1'b0;
      chan_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        st_q    <= S_IDLE;
        power_o <= 1'b0;
        hold_o  <= 1'b0;
      end else begin
        case (st_q)
          S_IDLE: begin
            if (start_i) begin
              st_q    <= S_WAKE;
              cnt_q   <= WAKE_CYC - 16'h0001;
              chan_o  <= chan_i;
              power_o <= 1'b1;
            end
          end
          S_WAKE: begin
            if (cnt_q == 16'h0000) begin
              st_q   <= S_CONV;
              cnt_q  <= CONV_CYC - 16'h0001;
              hold_o <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          S_CONV: begin
            if (cnt_q == 16'h0000) begin
              // The core drops back to shutdown as soon as its result is out.
              st_q    <= S_IDLE;
              hold_o  <= 1'b0;
              power_o <= 1'b0; // R16
              done_o  <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // adc_conv_sequencer

// ==== include/adc_trigger_regs.vh ====
// Register map, field positions, reset values and timing figures of the conversion trigger.
`ifndef ADC_TRIGGER_REGS_VH
`define ADC_TRIGGER_REGS_VH

// Register pointer values carried in the low nibble of the pointer byte.
`define PTR_RESULT        4'h0
`define PTR_CONFIG        4'h2
`define PTR_CYCLE         4'h3

// Pointer byte layout.
`define PTR_FIELD_MSB     3
`define CMD_FIRST_BIT     4
`define CMD_SECOND_BIT    5

// Configuration and cycle timer layout.
`define CFG_CH_LOWER_BIT  4
`define CFG_CH_UPPER_BIT  5
`define CYC_CODE_MSB      2

// Reset values.
`define CFG_RESET         8'h00
`define CYC_RESET         8'h00

// Bit counts at which power-up is decided inside the pointer byte and at which a byte is complete.
`define CMD_DECIDE_FALL   4'h5
`define BYTE_BITS         4'h8

// Timing figures.
`define CLK_MHZ           250
`define WAKE_NS           1000
`define CONV_NS           2000

`endif

// ==== testbench/adc_trigger_checker.sv ====
// Concurrent checks on the pins of the conversion trigger, bound to its top module.
`timescale 1ns/10ps
`include "adc_trigger_regs.vh"
module adc_trigger_checker (
  input wire        CORE_CLK_I,
  input wire        RESET_I,
  input wire        SCL_I,
  input wire        SCL_O,
  input wire        SCL_OE_O,
  input wire        SDA_I,
  input wire        SDA_O,
  input wire        SDA_OE_O,
  input wire [11:0] SAR_RESULT_I,
  input wire        ANALOG_POWER_UP_O,
  input wire        SAMPLE_HOLD_O,
  input wire [1:0]  CHANNEL_SEL_O,
  input wire        CONV_BUSY_O
);
  localparam int WAKE_C = `CLK_MHZ * `WAKE_NS / 1000;
  localparam int CONV_C = `CLK_MHZ * `CONV_NS / 1000;
  logic [15:0] wake_q;
  logic [15:0] hold_q;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  // Wake_q counts powered cycles before hold, hold_q counts cycles spent in hold.
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wake_q <= 16'h0000;
      hold_q <= 16'h0000;
    end else begin
      wake_q <= (ANALOG_POWER_UP_O && !SAMPLE_HOLD_O) ? wake_q + 16'h0001 : 16'h0000;
      hold_q <= SAMPLE_HOLD_O ? hold_q + 16'h0001 : 16'h0000;
    end
  end
  property p_wake_len;
    $rose(ANALOG_POWER_UP_O) |-> ##250 (SAMPLE_HOLD_O || !ANALOG_POWER_UP_O);
  endproperty
  property p_wake_max;
    $rose(SAMPLE_HOLD_O) |-> wake_q <= 16'(WAKE_C);
  endproperty
  property p_hold_len;
    SAMPLE_HOLD_O |-> hold_q < 16'(CONV_C);
  endproperty
  property p_hold_pwr;
    SAMPLE_HOLD_O |-> ANALOG_POWER_UP_O;
  endproperty
  property p_pwr_busy;
    ANALOG_POWER_UP_O |-> CONV_BUSY_O;
  endproperty
  property p_one_hot;
    $onehot(CHANNEL_SEL_O);
  endproperty
  property p_chan_hold;
    SAMPLE_HOLD_O && $past(SAMPLE_HOLD_O) |-> $stable(CHANNEL_SEL_O);
  endproperty
  property p_str_start;
    $rose(SCL_OE_O) |-> !SCL_I && CONV_BUSY_O;
  endproperty
  property p_str_busy;
    SCL_OE_O |-> CONV_BUSY_O || $past(CONV_BUSY_O) || $past(CONV_BUSY_O, 2)
      || $past(CONV_BUSY_O, 3);
  endproperty
  property p_sda_scl;
    $changed(SDA_OE_O) |-> !SCL_I;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake phase length wrong");
  a_wake_max: assert property (p_wake_max) else $error("wake phase too long");
  a_hold_len: assert property (p_hold_len) else $error("hold phase too long");
  a_hold_pwr: assert property (p_hold_pwr) else $error("hold while unpowered");
  a_pwr_busy: assert property (p_pwr_busy) else $error("powered while idle");
  a_one_hot: assert property (p_one_hot) else $error("channel select not one-hot");
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved in hold");
  a_str_start: assert property (p_str_start) else $error("stretch start wrong");
  a_str_busy: assert property (p_str_busy) else $error("stretch without conversion");
  a_sda_scl: assert property (p_sda_scl) else $error("data moved while clock high");
  c_stretch: cover property ($rose(SCL_OE_O));
  c_result: cover property ($fell(SAMPLE_HOLD_O));
  c_second: cover property (SAMPLE_HOLD_O && CHANNEL_SEL_O == 2'b10);
  c_power: cover property ($rose(ANALOG_POWER_UP_O));
endmodule // adc_trigger_checker

bind adc_command_and_cycle_trigger adc_trigger_checker i_adc_trigger_checker (
  .CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE_O(SCL_OE_O), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .SAR_RESULT_I(SAR_RESULT_I), .ANALOG_POWER_UP_O(ANALOG_POWER_UP_O),
  .SAMPLE_HOLD_O(SAMPLE_HOLD_O), .CHANNEL_SEL_O(CHANNEL_SEL_O), .CONV_BUSY_O(CONV_BUSY_O));

// ==== testbench/i2c_host_model.sv ====
// Bus master model that drives the two-wire port through open-drain pull-downs.
`timescale 1ns/10ps
module i2c_host_model #(
  parameter int H = 5
) (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_low_o,
  output logic      sda_low_o
);
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Releases the clock and waits while the device stretches it.
  task automatic rise();
    scl_low_o <= 1'b0;
    tick(1);
    for (int k = 0; k < 8000 && !scl_i; k++) tick(1);
    tick(H);
  endtask
  // Serves as first or repeated start; the clock is idle or low on entry.
  task automatic start();
    sda_low_o <= 1'b0;
    tick(H);
    rise();
    sda_low_o <= 1'b1;
    tick(H);
    scl_low_o <= 1'b1;
    tick(H);
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    tick(H);
    rise();
    sda_low_o <= 1'b0;
    tick(H);
  endtask
  task automatic bitx(input logic b, output logic s);
    sda_low_o <= !b;
    tick(H);
    rise();
    s = sda_i;
    scl_low_o <= 1'b1;
    tick(H);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask
  // A not-acknowledge on the last byte ends the read.
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(!ack, s);
  endtask
endmodule // i2c_host_model

// ==== testbench/test_adc_command_and_cycle_trigger.sv ====
// Self-checking bench for the conversion trigger driven by a bus master model.
`timescale 1ns/10ps
module test_adc_command_and_cycle_trigger;
  localparam logic [6:0] DEV = 7'h28;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] sar = 12'h000;
  logic        m_scl;
  logic        m_sda;
  logic        scl_oe;
  logic        sda_oe;
  logic        pwr;
  logic        hold;
  logic        busy;
  logic        chb;
  logic        ack;
  logic        seen;
  logic [1:0]  chan;
  logic [1:0]  ch_exp;
  logic [7:0]  rd [2];
  logic [11:0] v [2];
  int          err_total = 0;
  int          n_checks = 0;
  int          n_str = 0;
  int          cyc = 0;
  int          s0;
  int          t [3];
  int          code;
  int          cfg;
  wire         scl_w = !(m_scl || scl_oe);
  wire         sda_w = !(m_sda || sda_oe);
  always #2 clk = !clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (scl_oe === 1'b1) n_str <= n_str + 1;
  end
  adc_command_and_cycle_trigger #(
    .INTERVAL_US_1(32'd4), .INTERVAL_US_2(32'd5), .INTERVAL_US_3(32'd6),
    .INTERVAL_US_4(32'd7), .INTERVAL_US_5(32'd8)
  ) i_adc_command_and_cycle_trigger (
    .CORE_CLK_I(clk), .RESET_I(rst), .SCL_I(scl_w), .SCL_O(), .SCL_OE_O(scl_oe),
    .SDA_I(sda_w), .SDA_O(), .SDA_OE_O(sda_oe), .SAR_RESULT_I(sar),
    .ANALOG_POWER_UP_O(pwr), .SAMPLE_HOLD_O(hold), .CHANNEL_SEL_O(chan), .CONV_BUSY_O(busy));
  i2c_host_model i_i2c_host_model (
    .clk_i(clk), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished with %0d mismatches so far", s, err_total);
  endtask
  task automatic put(input logic [7:0] b, input logic exp);
    i_i2c_host_model.wbyte(b, ack);
    chk("ack", ack, exp);
  endtask
  task automatic set_reg(input logic [7:0] pb, input logic [7:0] d, input int n);
    i_i2c_host_model.start();
    put({DEV, 1'b0}, 1'b1);
    put(pb, 1'b1);
    if (n > 0) put(d, 1'b1);
    i_i2c_host_model.stop();
  endtask
  task automatic get1(input logic [7:0] exp, input string what);
    i_i2c_host_model.start();
    put({DEV, 1'b1}, 1'b1);
    i_i2c_host_model.rbyte(1'b0, rd[0]);
    i_i2c_host_model.stop();
    chk(what, rd[0], exp);
  endtask
  task automatic wait_start(output int ts);
    for (int w = 0; w < 6000 && busy !== 1'b0; w++) @(negedge clk);
    chk("power down", pwr, 1'b0);
    for (int w = 0; w < 6000 && busy !== 1'b1; w++) @(negedge clk);
    ts = cyc;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(36));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk("reset chan", chan, 2'b01);
    chk("reset outputs", {scl_oe, sda_oe, pwr, hold, busy}, 5'h00);
    i_i2c_host_model.start();
    put({~DEV, 1'b0}, 1'b0);
    i_i2c_host_model.stop();
    set_reg(8'h02, 8'h00, 0);
    get1(8'h00, "config reset");
    set_reg(8'h03, 8'h00, 0);
    get1(8'h00, "cycle reset");
    set_reg(8'h05, 8'h00, 0);
    get1(8'h00, "unmapped");
    done("registers");
    for (int c = 0; c < 4; c++) begin
      v[0] = 12'($urandom);
      v[1] = 12'($urandom);
      @(posedge clk) sar <= v[0];
      i_i2c_host_model.start();
      put({DEV, 1'b0}, 1'b1);
      fork
        put({2'b00, 2'(c), 4'h0}, 1'b1);
        begin
          repeat (4) @(negedge scl_w);
          chk("early start", busy, 1'b0);
          @(negedge scl_w);
          repeat (3) @(negedge clk);
          chk("start", {busy, pwr}, {2{c != 0}});
        end
      join
      if (c == 0) begin
        i_i2c_host_model.stop();
        chk("idle", busy, 1'b0);
        continue;
      end
      s0 = n_str;
      i_i2c_host_model.start();
      put({DEV, 1'b1}, 1'b1);
      chk("stretch", n_str > s0, 1'b1);
      for (int k = 0; k < 2; k++) begin
        chb = (c == 3) ? k[0] : (c == 2);
        i_i2c_host_model.rbyte(1'b1, rd[0]);
        if (k == 0) begin
          // With both inputs, input two finishes while the master holds the clock low inside the first pair.
          @(posedge clk) sar <= v[1];
          repeat (800) @(posedge clk);
        end
        i_i2c_host_model.rbyte(k == 0, rd[1]);
        // A restarted single input has no new result yet, so its second pair repeats.
        chk("result", {rd[0], rd[1]}, {3'b000, chb, v[(c == 3) ? k : 0]});
        if (k == 0) begin
          repeat (20) @(negedge clk);
          chk("continue", busy, 1'b1);
        end
      end
      i_i2c_host_model.stop();
      repeat (3) @(negedge clk);
      chk("abort", {busy, pwr}, 2'b00);
      done("command");
    end
    for (int r = 0; r < 2; r++) begin
      cfg = 1 + $urandom % 3;
      code = 1 + $urandom % 5;
      set_reg(8'h02, {2'b00, 2'(cfg), 4'h0}, 1);
      set_reg(8'h03, 8'(code), 1);
      for (int k = 0; k < 3; k++) begin
        wait_start(t[k]);
        ch_exp = (cfg == 3) ? 2'(1 << (k % 2)) : 2'(cfg);
        chk("cycle chan", chan, ch_exp);
      end
      chk("interval", 16'(t[2] - t[1]), 16'((code + 3) * 250));
      set_reg(8'h03, 8'h00, 0);
      get1(8'(code), "cycle value");
      set_reg(8'h03, 8'h00, 1);
      seen = 1'b0;
      for (int w = 0; w < 6000 && busy !== 1'b0; w++) @(negedge clk);
      repeat (3000) begin
        @(negedge clk);
        seen = seen | busy;
      end
      chk("cycle stop", seen, 1'b0);
      done("cycle");
    end
    tally_and_finish();
  end
endmodule // test_adc_command_and_cycle_trigger
